//--- design/epi_channel.sv
// One external interrupt channel: pin select, synchroniser, polarity, detection.
// Assumes the port pins are asynchronous to pclk; the acknowledge is a pclk pulse.
`timescale 1ns/100ps
module epi_channel #(
	parameter int unsigned PORT_WIDTH = epi_pkg::EPI_PORT_WIDTH,
	parameter int unsigned SEL_WIDTH = epi_pkg::EPI_SEL_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [PORT_WIDTH-1:0] port_pins,
	input wire logic [SEL_WIDTH-1:0] pin_select,
	input wire logic polarity,
	input wire logic edge_select,
	input wire logic vector_ack,
	input wire logic sw_write_en,
	input wire logic sw_write_val,
	output logic pending,
	output logic active_edge
);
	// Two-stage synchroniser; only the second stage is looked at
	logic [1:0] sync;
	// Marks that the synchroniser holds real pin samples; its reset zeros would
	// otherwise look active under low polarity and fake a request after reset
	logic [1:0] primed;
	// Previous corrected level, for edge detection
	logic prev_active;
	logic edge_flag;
	// Pin picked by the select field, never driven back
	wire raw_pin = port_pins[pin_select];
	// Corrected level after the second flop
	wire level_active = primed[1] & (polarity ? sync[1] : ~sync[1]);
	wire edge_seen = level_active & ~prev_active;
	// Level mode follows the input; edge mode uses the latched flag
	assign pending = edge_select ? edge_flag : level_active;
	assign active_edge = edge_seen;

	// Synchronise the selected pin before any decoding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync <= epi_pkg::EPI_SYNC_RESET;
		end else begin
			sync <= {sync[0], raw_pin};
		end
	end

	// Priming shift: high once both synchroniser stages carry pin samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primed <= epi_pkg::EPI_SYNC_RESET;
		end else begin
			primed <= {primed[0], 1'b1};
		end
	end

	// Edge history; reset to inactive so a pin already active reads as an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_active <= 1'b0;
		end else begin
			prev_active <= level_active;
		end
	end

	// Edge flag: a new edge wins over acknowledge or software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_flag <= 1'b0;
		end else if (edge_select && edge_seen) begin
			edge_flag <= 1'b1;
		end else if (vector_ack || !edge_select) begin
			edge_flag <= 1'b0;
		end else if (sw_write_en) begin
			edge_flag <= sw_write_val;
		end
	end

	chk_edge_sets: assert property (@(posedge pclk) disable iff (!presetn)
		edge_select && edge_seen |=> edge_flag)
		else $error("edge did not set pending");
	chk_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
		edge_select && $past(edge_select) && vector_ack && !edge_seen |=> !edge_flag)
		else $error("acknowledge did not clear pending");
	chk_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
		!edge_select && primed[1] |-> pending == (polarity ? sync[1] : ~sync[1]))
		else $error("level pending does not follow input");
	chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) && $stable(pin_select) && $past(pin_select) == pin_select
		|=> sync[1] == $past(port_pins[pin_select], 2))
		else $error("synchroniser delay wrong");
	cov_edge_event: cover property (@(posedge pclk) disable iff (!presetn)
		edge_select && edge_seen ##1 vector_ack);
endmodule

//--- design/epi_pkg.sv
// Constants, register map and field layout for the external pin interrupt block.
// Assumes an APB master on pclk and an 8-bit port whose pins arrive asynchronously.
// Overview of operation
// - Polarity bit zero means active low input
// - Trigger bit one edge, zero level detection
// - Sample selected pin, never drive it
// - One pending flag per channel requests interrupt
// - Edge sets flag, vector acknowledge clears it
// - Level mode flag follows active input
// - Still-active level input requests again
// - Three-bit select picks port pin 0..7
package epi_pkg;
	localparam int unsigned EPI_PORT_WIDTH = 8;
	localparam int unsigned EPI_SEL_WIDTH = 3;
	localparam int unsigned EPI_CHANNELS = 2;
	// Byte addresses of the word-aligned registers
	localparam logic [11:0] EPI_ADDR_CONFIG = 12'h000;
	localparam logic [11:0] EPI_ADDR_CONTROL = 12'h004;
	localparam logic [11:0] EPI_ADDR_STATUS = 12'h008;
	localparam logic [11:0] EPI_ADDR_MASK = 12'h00C;
	// Configuration register fields
	localparam int unsigned EPI_A_SEL_LSB = 0;
	localparam int unsigned EPI_A_POL_BIT = 3;
	localparam int unsigned EPI_B_SEL_LSB = 4;
	localparam int unsigned EPI_B_POL_BIT = 7;
	localparam logic [7:0] EPI_CONFIG_RESET = 8'h01;
	// Control register fields: edge selects and pending flags
	localparam int unsigned EPI_A_EDGE_BIT = 0;
	localparam int unsigned EPI_A_PEND_BIT = 1;
	localparam int unsigned EPI_B_EDGE_BIT = 2;
	localparam int unsigned EPI_B_PEND_BIT = 3;
	localparam logic [3:0] EPI_CONTROL_RESET = 4'h0;
	localparam logic [1:0] EPI_STATUS_RESET = 2'h0;
	localparam logic [1:0] EPI_MASK_RESET = 2'h0;
	localparam logic [1:0] EPI_SYNC_RESET = 2'h0;
endpackage

//--- design/epi_top.sv
// Top of the external pin interrupt block: APB slave, registers, two channels.
// Assumes an APB master on pclk and a CPU that pulses a vector acknowledge per channel.
`timescale 1ns/100ps
module epi_top #(
	parameter int unsigned PORT_WIDTH = epi_pkg::EPI_PORT_WIDTH,
	parameter int unsigned SEL_WIDTH = epi_pkg::EPI_SEL_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PORT_WIDTH-1:0] port_pins,
	input wire logic ack_irq_a,
	input wire logic ack_irq_b,
	output logic ext_irq_a,
	output logic ext_irq_b,
	output logic irq
);
	// Configuration: selects and polarities, layout as the config register
	logic [7:0] ext_irq_config_reg;
	// Edge selects stored here; pending bits are read live from the channels
	logic irq_a_edge_select;
	logic irq_b_edge_select;
	// Sticky event status and its mask
	logic [1:0] status;
	logic [1:0] mask;
	logic irq_a_pending;
	logic irq_b_pending;
	logic edge_a;
	logic edge_b;

	// Bus decode: zero-wait slave, write takes effect in the access cycle
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire hit_cfg = paddr == epi_pkg::EPI_ADDR_CONFIG;
	wire hit_ctl = paddr == epi_pkg::EPI_ADDR_CONTROL;
	wire hit_sts = paddr == epi_pkg::EPI_ADDR_STATUS;
	wire hit_msk = paddr == epi_pkg::EPI_ADDR_MASK;
	wire mapped = hit_cfg | hit_ctl | hit_sts | hit_msk;
	wire wr_ctl = wr & hit_ctl;

	// Field extraction from the configuration register
	wire [SEL_WIDTH-1:0] irq_a_pin_select =
		ext_irq_config_reg[epi_pkg::EPI_A_SEL_LSB +: SEL_WIDTH];
	wire [SEL_WIDTH-1:0] irq_b_pin_select =
		ext_irq_config_reg[epi_pkg::EPI_B_SEL_LSB +: SEL_WIDTH];
	wire irq_a_polarity = ext_irq_config_reg[epi_pkg::EPI_A_POL_BIT];
	wire irq_b_polarity = ext_irq_config_reg[epi_pkg::EPI_B_POL_BIT];

	// Control register image: pending flags live, edge selects stored
	wire [3:0] ctl_image = {irq_b_pending, irq_b_edge_select, irq_a_pending, irq_a_edge_select};
	wire [1:0] events = {edge_b, edge_a};
	wire [1:0] sts_clear = (wr & hit_sts) ? pwdata[1:0] : 2'h0;
	// Set wins over clear in the same cycle
	wire [1:0] next_status = (status & ~sts_clear) | events;
	wire [31:0] next_prdata =
		hit_cfg ? {24'h000000, ext_irq_config_reg} :
		hit_ctl ? {28'h0000000, ctl_image} :
		hit_sts ? {30'h00000000, status} :
		hit_msk ? {30'h00000000, mask} : 32'h00000000;

	epi_channel #(.PORT_WIDTH(PORT_WIDTH), .SEL_WIDTH(SEL_WIDTH)) u_chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.port_pins(port_pins),
		.pin_select(irq_a_pin_select),
		.polarity(irq_a_polarity),
		.edge_select(irq_a_edge_select),
		.vector_ack(ack_irq_a),
		.sw_write_en(wr_ctl),
		.sw_write_val(pwdata[epi_pkg::EPI_A_PEND_BIT]),
		.pending(irq_a_pending),
		.active_edge(edge_a)
	);

	epi_channel #(.PORT_WIDTH(PORT_WIDTH), .SEL_WIDTH(SEL_WIDTH)) u_chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.port_pins(port_pins),
		.pin_select(irq_b_pin_select),
		.polarity(irq_b_polarity),
		.edge_select(irq_b_edge_select),
		.vector_ack(ack_irq_b),
		.sw_write_en(wr_ctl),
		.sw_write_val(pwdata[epi_pkg::EPI_B_PEND_BIT]),
		.pending(irq_b_pending),
		.active_edge(edge_b)
	);

	// Configuration and control writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_config_reg <= epi_pkg::EPI_CONFIG_RESET;
			irq_a_edge_select <= epi_pkg::EPI_CONTROL_RESET[epi_pkg::EPI_A_EDGE_BIT];
			irq_b_edge_select <= epi_pkg::EPI_CONTROL_RESET[epi_pkg::EPI_B_EDGE_BIT];
			mask <= epi_pkg::EPI_MASK_RESET;
		end else begin
			if (wr & hit_cfg) begin
				ext_irq_config_reg <= pwdata[7:0];
			end
			if (wr_ctl) begin
				irq_a_edge_select <= pwdata[epi_pkg::EPI_A_EDGE_BIT];
				irq_b_edge_select <= pwdata[epi_pkg::EPI_B_EDGE_BIT];
			end
			if (wr & hit_msk) begin
				mask <= pwdata[1:0];
			end
		end
	end

	// Sticky edge status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= epi_pkg::EPI_STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// Registered bus answers: ready low in reset and high from the first clock after it, error on unmapped access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			prdata <= (psel & ~penable & ~pwrite) ? next_prdata : prdata;
			// Held through the access cycle so the master sees it at its pready edge
			pslverr <= psel & ~mapped;
		end
	end

	// Interrupt requests to the CPU, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_a <= 1'b0;
			ext_irq_b <= 1'b0;
			irq <= 1'b0;
		end else begin
			ext_irq_a <= irq_a_pending;
			ext_irq_b <= irq_b_pending;
			irq <= |(next_status & mask);
		end
	end

	chk_req_follows: assert property (@(posedge pclk) disable iff (!presetn)
		##1 ext_irq_a == $past(irq_a_pending))
		else $error("channel a request does not track pending");
	chk_level_again: assert property (@(posedge pclk) disable iff (!presetn)
		!irq_b_edge_select && irq_b_pending && ack_irq_b |=> ext_irq_b)
		else $error("still active level input lost its request");
	chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		edge_a |=> status[0])
		else $error("edge event lost from status");
	chk_irq_mask: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq == |($past(next_status) & $past(mask)))
		else $error("interrupt output does not match masked status");
	chk_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_cfg |=> ext_irq_config_reg == $past(pwdata[7:0]))
		else $error("configuration write lost");
	chk_edge_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctl |=> irq_b_edge_select == $past(pwdata[epi_pkg::EPI_B_EDGE_BIT]))
		else $error("edge select write lost");
	cov_level_b: cover property (@(posedge pclk) disable iff (!presetn)
		!irq_b_edge_select && ext_irq_b);
	cov_masked_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

//--- verification/epi_src_model.sv
// Model of the external interrupt source that drives the port pins.
// Assumes the bench tells it, once per pclk edge, which level each pin should take.
`timescale 1ns/100ps
module epi_src_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] want_level,
	output logic [7:0] port_pins
);
	// Pins are reserved for the interrupt channels, so nothing else drives them
	// Each level is held until the bench releases it; the bench keeps it active
	// until the request is taken and drops it before the handler ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Idle high so the active-low default config sees no request
			port_pins <= 8'hFF;
		end else begin
			port_pins <= want_level;
		end
	end
endmodule

//--- verification/epi_top_tb.sv
// Self-checking bench for the external pin interrupt block.
// Assumes the APB slave answers with pready and the source model drives the pins.
`timescale 1ns/100ps
module epi_top_tb;
	logic pclk, presetn, psel, penable, pwrite, ack_irq_a, ack_irq_b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, ext_irq_a, ext_irq_b, irq;
	logic [7:0] want_level, port_pins;
	int num_errors = 0;
	int cmp_count = 0;

	epi_src_model src (.pclk(pclk), .presetn(presetn), .want_level(want_level),
		.port_pins(port_pins));
	epi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_pins(port_pins), .ack_irq_a(ack_irq_a),
		.ack_irq_b(ack_irq_b), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .irq(irq));

	// Free-running 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Verdict in one place; also reached when a wait runs out
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Compare seen against expected and count it
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the wait for pready is bounded so a stuck slave cannot hang us
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One-cycle vector acknowledge for channel a (0) or b (1)
	task automatic ack(input logic b);
		if (b) ack_irq_b <= 1'b1;
		else ack_irq_a <= 1'b1;
		@(posedge pclk);
		ack_irq_a <= 1'b0;
		ack_irq_b <= 1'b0;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, ack_irq_a, ack_irq_b} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		want_level = 8'hFF;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and a refused unmapped access
		apb(1'b0, epi_pkg::EPI_ADDR_CONFIG, 32'h0); chk(rd, 32'h00000001);
		apb(1'b0, epi_pkg::EPI_ADDR_CONTROL, 32'h0); chk(rd, 32'h00000000);
		apb(1'b0, 12'h010, 32'h0); chk({rd[30:0], err}, 32'h00000001);
		$display("reset test done");
		// Level, active low on pin 1: flag follows pin, acknowledge does not clear it
		want_level <= 8'hFD;
		tick(5); chk(ext_irq_a, 1'b1);
		apb(1'b0, epi_pkg::EPI_ADDR_CONTROL, 32'h0); chk(rd, 32'h00000002);
		ack(1'b0);
		tick(3); chk(ext_irq_a, 1'b1);
		want_level <= 8'hFF;
		tick(5); chk(ext_irq_a, 1'b0);
		$display("level test done");
		// Every pin code on channel b, both active high, level mode
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, epi_pkg::EPI_ADDR_CONFIG, 32'h88 | (i << 4));
			want_level <= 8'h01 << i;
			tick(5); chk(ext_irq_b, 1'b1);
			want_level <= ~(8'h01 << i);
			tick(5); chk(ext_irq_b, 1'b0);
		end
		$display("pin select test done");
		// Edge mode: a on pin 2 active high, b on pin 0 active low
		apb(1'b1, epi_pkg::EPI_ADDR_CONFIG, 32'h0A);
		apb(1'b1, epi_pkg::EPI_ADDR_CONTROL, 32'h05);
		apb(1'b1, epi_pkg::EPI_ADDR_MASK, 32'h01);
		// Earlier level-mode pin changes left edge events in status; start clean
		apb(1'b1, epi_pkg::EPI_ADDR_STATUS, 32'h03);
		want_level <= 8'h01;
		tick(6); chk(ext_irq_a, 1'b0);
		want_level <= 8'h05;
		tick(6); chk({ext_irq_a, irq}, 2'h3);
		apb(1'b0, epi_pkg::EPI_ADDR_STATUS, 32'h0); chk(rd, 32'h00000001);
		tick(5); chk(ext_irq_a, 1'b1);
		ack(1'b0);
		tick(3); chk(ext_irq_a, 1'b0);
		apb(1'b1, epi_pkg::EPI_ADDR_STATUS, 32'h01);
		tick(3); chk(irq, 1'b0);
		want_level <= 8'h04;
		tick(6); chk({ext_irq_b, irq}, 2'h2);
		apb(1'b0, epi_pkg::EPI_ADDR_CONTROL, 32'h0); chk(rd, 32'h0000000D);
		apb(1'b0, epi_pkg::EPI_ADDR_STATUS, 32'h0); chk(rd, 32'h00000002);
		apb(1'b1, epi_pkg::EPI_ADDR_MASK, 32'h03);
		tick(3); chk(irq, 1'b1);
		ack(1'b1);
		apb(1'b1, epi_pkg::EPI_ADDR_STATUS, 32'h02);
		tick(3); chk({ext_irq_b, irq}, 2'h0);
		$display("edge test done");
		wrap_up();
	end
endmodule
